// ===== src/wdt_map.svh
// register map, field positions, reset values and timing counts of the watchdog
// Functional notes
// - period code 000 gives 16K machine cycles, code 111 gives 2048K
// - each step of the period code doubles the watchdog period
// - one machine cycle equals twelve oscillator (clock) periods
// - watchdog disabled after power-on reset and held during power-down
// - unserviced expiry produces an internal reset pulse for the processor
// - idle_freeze 0 counts in idle; 1 freezes count while idle lasts
// - reset_out_disable 0 drives reset pin high after a timeout
// - reset_out_disable 1 leaves reset pin as input, resets core only
// - software mode: run_enable alone starts and stops the watchdog
// - hardware mode: writes 1E then E1 to restart register start counting
// - once started in hardware mode it runs until warm or cold reset
// - hardware mode: each complete 1E/E1 sequence restarts the count
// - software mode: counter_clear clears count, self-clears next machine cycle
// - hardware mode: counter_clear has no effect and stays set
// - software mode: clearing run_enable holds count; setting resumes from it
// - hardware mode: run_enable is read-only and shows running status
// - control register resets to all zeros
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

`define WDT_IDX_RESTART 8'hA6
`define WDT_IDX_CONTROL 8'hA7

`define WDT_B_RUN 0
`define WDT_B_CLR 1
`define WDT_B_HW 2
`define WDT_B_RTO 3
`define WDT_B_IDLE 4
`define WDT_PS_MSB 7
`define WDT_PS_LSB 5

`define WDT_CTRL_RST 8'h00
`define WDT_SEQ_FIRST 8'h1E
`define WDT_SEQ_SECOND 8'hE1

`define WDT_CNT_W 22
`define WDT_OSC_PER_MC 12
`define WDT_BASE_KMC 16
`define WDT_BASE_MC (`WDT_BASE_KMC * 1024)
`define WDT_PULSE_MC 4'h2

`endif

// ===== src/wdt_pkg.sv
// types shared by the watchdog design files
`include "wdt_map.svh"

package wdt_pkg;

    typedef enum logic [1:0] {
        WDT_STOP = 2'b00,
        WDT_RUN = 2'b01,
        WDT_BITE = 2'b11
    } wdt_state_e;

    typedef struct packed {
        wdt_state_e st;
        logic [7:0] ctrl;
        logic [`WDT_CNT_W-1:0] cnt;
        logic hw_run;
        logic armed;
        logic [3:0] pulse;
        logic core_rst;
        logic pin_drv;
        logic [7:0] rdata;
        logic idle_s1;
        logic idle_s2;
        logic pd_s1;
        logic pd_s2;
        logic pin_s1;
        logic pin_s2;
    } wdt_regs_s;

    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } wdt_presc_s;

endpackage

// ===== src/wdt_presc.sv
// machine-cycle tick generator: one pulse every twelve clocks
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_presc
    import wdt_pkg::*;
#(
    parameter int unsigned DIV = `WDT_OSC_PER_MC
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);

    wdt_presc_s s_r;
    wdt_presc_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt == 4'(DIV - 1)) begin
            s_nxt.cnt = 4'h0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

    tick_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> !tick [*8])
        else $error("machine-cycle tick came too early");

endmodule

// ===== src/wdt_top.sv
// watchdog unit: apb registers, period counter, hardware/software modes, reset output
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_top
    import wdt_pkg::*;
#(
    parameter int unsigned BASE_MC = `WDT_BASE_MC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic idle_mode,
    input wire logic power_down,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    output logic core_reset,
    output logic wd_running
);

    wdt_regs_s s_r;
    wdt_regs_s s_nxt;
    logic mc_tick;

    wdt_presc #(
        .DIV(`WDT_OSC_PER_MC)
    ) wdt_presc_i (
        .pclk(pclk),
        .presetn(presetn),
        .tick(mc_tick)
    );

    // address decode: register index sits in paddr[9:2], byte address is four times it
    logic hit_rst;
    logic hit_ctl;
    logic hit;
    logic setup;
    logic wr_acc;

    assign hit_rst = paddr[11:10] == 2'b00 && paddr[9:2] == `WDT_IDX_RESTART
        && paddr[1:0] == 2'b00;
    assign hit_ctl = paddr[11:10] == 2'b00 && paddr[9:2] == `WDT_IDX_CONTROL
        && paddr[1:0] == 2'b00;
    assign hit = hit_rst | hit_ctl;
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & hit;

    // zero wait state slave
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    logic hw_mode;
    logic sw_clr;
    logic frozen;
    logic run_cond;
    logic count_en;
    logic seq_done;
    logic [2:0] ps_code;
    logic [`WDT_CNT_W-1:0] period_w;
    logic [`WDT_CNT_W-1:0] cnt_inc;
    logic [7:0] ctl_view;

    assign hw_mode = s_r.ctrl[`WDT_B_HW];
    assign ps_code = s_r.ctrl[`WDT_PS_MSB:`WDT_PS_LSB];
    assign period_w = `WDT_CNT_W'(BASE_MC) << ps_code;
    assign cnt_inc = s_r.cnt + `WDT_CNT_W'(1);
    assign sw_clr = ~hw_mode & s_r.ctrl[`WDT_B_CLR];
    assign frozen = s_r.idle_s2 & s_r.ctrl[`WDT_B_IDLE];
    // power-down overrides every mode
    assign run_cond = ~s_r.pd_s2 & (hw_mode ? s_r.hw_run : s_r.ctrl[`WDT_B_RUN]);
    assign count_en = run_cond & mc_tick & ~frozen & ~sw_clr;
    assign seq_done = wr_acc & hit_rst & s_r.armed
        & pwdata[7:0] == `WDT_SEQ_SECOND;

    // run_enable reads back live status in hardware mode
    always_comb begin
        ctl_view = s_r.ctrl;
        if (hw_mode) begin
            ctl_view[`WDT_B_RUN] = s_r.st == WDT_RUN;
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.idle_s1 = idle_mode;
        s_nxt.idle_s2 = s_r.idle_s1;
        s_nxt.pd_s1 = power_down;
        s_nxt.pd_s2 = s_r.pd_s1;
        s_nxt.pin_s1 = rst_pin_in;
        s_nxt.pin_s2 = s_r.pin_s1;

        if (setup && !pwrite) begin
            s_nxt.rdata = hit_ctl ? ctl_view : 8'h00;
        end

        if (wr_acc && hit_ctl) begin
            s_nxt.ctrl = pwdata[7:0];
            if (hw_mode) begin
                s_nxt.ctrl[`WDT_B_RUN] = s_r.ctrl[`WDT_B_RUN];
            end
            if (s_r.hw_run) begin
                s_nxt.ctrl[`WDT_B_HW] = 1'b1;
            end
        end

        if (wr_acc && hit_rst) begin
            s_nxt.armed = pwdata[7:0] == `WDT_SEQ_FIRST;
        end

        // the self-clear waits for a machine-cycle boundary, as the cpu sees it
        // a fresh write of counter_clear in the tick cycle wins over the self-clear
        if (sw_clr && mc_tick && !(wr_acc && hit_ctl)) begin
            s_nxt.ctrl[`WDT_B_CLR] = 1'b0;
        end

        if (sw_clr) begin
            s_nxt.cnt = '0;
        end

        if (seq_done && hw_mode) begin
            s_nxt.hw_run = 1'b1;
            s_nxt.cnt = '0;
        end

        unique case (s_r.st)
            WDT_STOP: begin
                if (run_cond) begin
                    s_nxt.st = WDT_RUN;
                end
            end
            WDT_RUN: begin
                if (!run_cond) begin
                    s_nxt.st = WDT_STOP;
                end else if (count_en && !(seq_done && hw_mode)) begin
                    if (cnt_inc == period_w) begin
                        s_nxt.st = WDT_BITE;
                        s_nxt.cnt = '0;
                        s_nxt.pulse = 4'h0;
                        s_nxt.core_rst = 1'b1;
                        s_nxt.pin_drv = ~s_r.ctrl[`WDT_B_RTO];
                    end else begin
                        s_nxt.cnt = cnt_inc;
                    end
                end
            end
            WDT_BITE: begin
                // the bite is a warm reset of the watchdog itself as well
                s_nxt.ctrl = `WDT_CTRL_RST;
                s_nxt.hw_run = 1'b0;
                s_nxt.armed = 1'b0;
                s_nxt.cnt = '0;
                if (mc_tick) begin
                    s_nxt.pulse = s_r.pulse + 4'h1;
                    if (s_r.pulse == `WDT_PULSE_MC - 4'h1) begin
                        s_nxt.st = WDT_STOP;
                        s_nxt.core_rst = 1'b0;
                        s_nxt.pin_drv = 1'b0;
                    end
                end
            end
            default: begin
                s_nxt.st = WDT_STOP;
            end
        endcase

        // a warm reset on the pin stops even hardware mode; our own drive is ignored
        if (s_r.pin_s2 && s_r.st != WDT_BITE) begin
            s_nxt.ctrl = `WDT_CTRL_RST;
            s_nxt.hw_run = 1'b0;
            s_nxt.armed = 1'b0;
            s_nxt.cnt = '0;
            s_nxt.st = WDT_STOP;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.st <= WDT_STOP;
            s_r.ctrl <= `WDT_CTRL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = {24'h000000, s_r.rdata};
    assign rst_pin_out = s_r.pin_drv;
    assign rst_pin_oe = s_r.pin_drv;
    assign core_reset = s_r.core_rst;
    assign wd_running = s_r.st == WDT_RUN;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    timeout_when_a: assert property (
        s_r.st == WDT_RUN && count_en && !seq_done && !s_r.pin_s2
        && cnt_inc == period_w |=> s_r.st == WDT_BITE && core_reset)
        else $error("timeout not taken when count reached period");

    period_scale_a: assert property (
        (period_w >> ps_code) == `WDT_CNT_W'(BASE_MC))
        else $error("period does not double per code step");

    period_max_a: assert property (
        ps_code == 3'h7 |-> period_w == `WDT_CNT_W'(BASE_MC) * `WDT_CNT_W'(128))
        else $error("longest period is not 128 times the shortest");

    sw_clear_a: assert property (
        sw_clr && mc_tick && s_r.st != WDT_BITE && !s_r.pin_s2 && !wr_acc
        |=> !s_r.ctrl[`WDT_B_CLR] && s_r.cnt == '0)
        else $error("counter_clear did not self-clear or clear the count");

    hw_clear_stays_a: assert property (
        hw_mode && s_r.ctrl[`WDT_B_CLR] && s_r.st != WDT_BITE && !s_r.pin_s2
        && !wr_acc |=> s_r.ctrl[`WDT_B_CLR])
        else $error("counter_clear cleared in hardware mode");

    idle_freeze_a: assert property (
        s_r.st == WDT_RUN && frozen && !seq_done && !sw_clr && !s_r.pin_s2
        |=> $stable(s_r.cnt))
        else $error("count moved while frozen in idle");

    sw_hold_a: assert property (
        !hw_mode && !s_r.ctrl[`WDT_B_RUN] && !sw_clr && s_r.st != WDT_BITE
        && !s_r.pin_s2 |=> $stable(s_r.cnt))
        else $error("stopped watchdog lost or changed its count");

    powerdown_hold_a: assert property (
        s_r.pd_s2 && s_r.st != WDT_BITE && !sw_clr && !seq_done && !s_r.pin_s2
        |=> $stable(s_r.cnt))
        else $error("count moved during power-down");

    hw_locked_a: assert property (
        s_r.hw_run && s_r.st != WDT_BITE && !s_r.pin_s2
        |=> s_r.hw_run && s_r.ctrl[`WDT_B_HW])
        else $error("hardware mode watchdog was stopped");

    hw_start_a: assert property (
        seq_done && hw_mode && s_r.st != WDT_BITE && !s_r.pin_s2
        |=> s_r.hw_run && s_r.cnt == '0)
        else $error("restart sequence did not start or restart the count");

    pin_drive_a: assert property (
        s_r.st == WDT_RUN ##1 s_r.st == WDT_BITE
        |-> rst_pin_oe == !$past(s_r.ctrl[`WDT_B_RTO]) && core_reset)
        else $error("reset pin drive disagrees with reset_out_disable");

    run_view_a: assert property (
        hw_mode && setup && !pwrite && hit_ctl
        |=> prdata[`WDT_B_RUN] == $past(wd_running))
        else $error("run_enable does not show status in hardware mode");

    bite_sw_c: cover property (s_r.st == WDT_RUN && !hw_mode ##1 s_r.st == WDT_BITE);
    bite_hw_c: cover property (s_r.hw_run ##1 s_r.st == WDT_BITE);
    service_c: cover property (seq_done && s_r.hw_run);
    board_rst_c: cover property ($rose(rst_pin_oe));

endmodule

// ===== verification/wdt_tb_top.sv
// self-checking testbench of the watchdog unit
`timescale 1ns/1ps

module wdt_top_tb_top;
    localparam int BMC = 4;
    localparam logic [11:0] A_RST = 12'h298;
    localparam logic [11:0] A_CTL = 12'h29C;
    logic pclk, presetn, psel, penable, pwrite, idle_mode, power_down, rst_pin_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, serr, rst_pin_out, rst_pin_oe, core_reset, wd_running;
    int failures = 0;
    int total_checks = 0;
    int n;

    wdt_top #(.BASE_MC(BMC)) wdt_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
        .power_down(power_down), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe), .core_reset(core_reset), .wd_running(wd_running));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // sampled on the falling edge so the bite has settled
    task automatic wait_bite(input int lim);
        n = 0;
        while (core_reset !== 1'b1 && n < lim) begin
            @(negedge pclk);
            n++;
        end
    endtask

    task automatic bite_ok(input int lim);
        wait_bite(lim);
        chk({31'h0, core_reset}, 32'h1, "bite");
        repeat (40) @(posedge pclk);
    endtask

    task automatic t_reset();
        apb(1'b0, A_CTL, 32'h0);
        chk(rd, 32'h0, "control reset");
        chk({31'h0, wd_running}, 32'h0, "idle after reset");
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, serr}, 32'h1, "unmapped");
    endtask

    task automatic t_periods();
        int p;
        for (int c = 0; c < 8; c++) begin
            p = BMC << c;
            apb(1'b1, A_CTL, {24'h0, 3'(c), 1'b0, c[0], 3'b001});
            wait_bite(p * 12 + 40);
            chk({31'h0, n >= (p - 1) * 12 + 3 && n <= p * 12 + 2}, 32'h1, "period");
            chk({31'h0, core_reset}, 32'h1, "core pulse");
            chk({31'h0, rst_pin_oe}, {31'h0, ~c[0]}, "pin drive");
            chk({31'h0, rst_pin_out}, {31'h0, ~c[0]}, "pin level");
            repeat (40) @(posedge pclk);
            chk({31'h0, core_reset}, 32'h0, "pulse ended");
            apb(1'b0, A_CTL, 32'h0);
            chk(rd, 32'h0, "control after bite");
        end
    endtask

    task automatic t_hold();
        apb(1'b1, A_CTL, 32'h01);
        repeat (24) @(posedge pclk);
        apb(1'b1, A_CTL, 32'h00);
        wait_bite(300);
        chk(n, 300, "stopped");
        apb(1'b1, A_CTL, 32'h01);
        wait_bite(60);
        chk({31'h0, n <= 36}, 32'h1, "resume kept count");
        bite_ok(10);
    endtask

    task automatic t_clear();
        apb(1'b1, A_CTL, 32'h01);
        repeat (24) @(posedge pclk);
        apb(1'b1, A_CTL, 32'h03);
        wait_bite(36);
        chk(n, 36, "cleared count");
        apb(1'b0, A_CTL, 32'h0);
        chk(rd, 32'h01, "clear bit self clears");
        bite_ok(60);
    endtask

    task automatic t_idle();
        apb(1'b1, A_CTL, 32'h11);
        idle_mode <= 1'b1;
        wait_bite(300);
        chk(n, 300, "frozen in idle");
        idle_mode <= 1'b0;
        bite_ok(80);
        apb(1'b1, A_CTL, 32'h01);
        idle_mode <= 1'b1;
        bite_ok(80);
        idle_mode <= 1'b0;
        apb(1'b1, A_CTL, 32'h01);
        power_down <= 1'b1;
        wait_bite(300);
        chk(n, 300, "held in power-down");
        power_down <= 1'b0;
        bite_ok(80);
    endtask

    task automatic t_hw();
        apb(1'b1, A_CTL, 32'h05);
        wait_bite(100);
        chk({31'h0, wd_running}, 32'h0, "waits for sequence");
        apb(1'b1, A_RST, 32'h1E);
        apb(1'b1, A_RST, 32'hE1);
        repeat (2) @(posedge pclk);
        chk({31'h0, wd_running}, 32'h1, "started");
        apb(1'b1, A_CTL, 32'h06);
        apb(1'b0, A_CTL, 32'h0);
        chk(rd, 32'h07, "run read-only, clear sticky");
        for (int i = 0; i < 4; i++) begin
            wait_bite(20);
            chk(n, 20, "serviced");
            apb(1'b1, A_RST, 32'h1E);
            apb(1'b1, A_RST, 32'hE1);
        end
        apb(1'b1, A_CTL, 32'h00);
        repeat (2) @(posedge pclk);
        chk({31'h0, wd_running}, 32'h1, "hw mode cannot be stopped");
        apb(1'b1, A_RST, 32'h1E);
        apb(1'b1, A_RST, 32'h55);
        apb(1'b1, A_RST, 32'hE1);
        bite_ok(50);
        apb(1'b1, A_CTL, 32'h04);
        apb(1'b1, A_RST, 32'h1E);
        apb(1'b1, A_RST, 32'hE1);
        rst_pin_in <= 1'b1;
        repeat (4) @(posedge pclk);
        rst_pin_in <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({31'h0, wd_running}, 32'h0, "warm reset stops");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        idle_mode = 1'b0;
        power_down = 1'b0;
        rst_pin_in = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_periods();
        t_hold();
        t_clear();
        t_idle();
        t_hw();
        stop_test();
    end

    // whole run is near 14.5k clocks; this limit only cuts a hang short
    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        stop_test();
    end
endmodule
